//--- uesev_map.vh
// register map and field layout of the uncorrectable error severity block
// included by the severity register bank; definitions only
`ifndef UESEV_MAP_VH
`define UESEV_MAP_VH

// byte address of the severity word
`define UESEV_OFFSET 12'h10C
// byte address of the control word holding the reporting controls
`define UESEV_CTRL_OFFSET 12'h200

// field positions
`define SEV_CPL_TIMEOUT_BIT 14
`define SEV_CPL_ABORT_BIT 15
`define SEV_UNEXP_CPL_BIT 16
`define SEV_RXOVR_BIT 17
`define SEV_MALF_BIT 18
`define SEV_ECRC_BIT 19
`define SEV_UNSUP_REQ_BIT 20
`define SEV_ACC_VIOL_BIT 21
`define SEV_INTERR_BIT 22
`define SEV_MCBLK_BIT 23

// programmable field range
`define SEV_LO 16
`define SEV_HI 23
`define SEV_W 8

// reset value of bits 23:16
`define SEV_RESET 8'h46

// control word bits
`define CTRL_IERR_EN_BIT 0
`define CTRL_MCER_DIS_BIT 1
`define CTRL_RESET 2'h0

`endif

//--- sev_field.v
// one sticky severity bit with an optional read-only override
// runs on pclk; power-on reset is the only reset that loads it, to RESET_VAL
`default_nettype none
module sev_field #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock and power-on reset
  input wire pclk,
  input wire por_n,
  // write path
  input wire wr_en,
  input wire wr_bit,
  // forced read-only
  input wire force_en,
  input wire force_val,
  // value seen by software and the reporting path
  output wire value
);
  reg bit_r;

  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      bit_r <= RESET_VAL;
    end else if (wr_en && !force_en) begin
      bit_r <= wr_bit;
    end
  end

  assign value = force_en ? force_val : bit_r;
endmodule // sev_field
`default_nettype wire

//--- uncorrectable_error_severity_upper.v
// upper half of the uncorrectable error severity register, APB slave
// assumes single pclk domain; presetn resets bus state and report outputs, por_n
// resets sticky fields; control inputs are synchronous to pclk
//
// Contract
// - field one reports fatal, zero non-fatal
// - bits 17, 18, 22 sticky RW, reset one
// - bits 16,19,20,21,23 sticky RW, reset zero
// - bit 14 reads zero always
// - bit 15 reads zero always
// - internal enable low forces bit 22 one
// - multicast disable low forces bit 23 zero
// - severity word at offset 0x10C
//
// Local design decisions: register access over APB and the register addresses.
`include "uesev_map.vh"
`default_nettype none
module uncorrectable_error_severity_upper (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // power-on reset for sticky fields
  input wire por_n,
  // error events, one bit per field 23:16
  input wire [7:0] err_event,
  // severity outcome per event, registered
  output reg [7:0] fatal_report,
  output reg [7:0] nonfatal_report,
  // current severity word for the reporting path
  output reg [7:0] severity
);
  // access phase helpers
  wire access;
  wire commit;
  wire hit_sev;
  wire hit_ctrl;
  wire wr_sev;
  wire wr_ctrl;
  wire [7:0] sev_val;
  wire [7:0] force_en;
  wire [7:0] force_val;
  wire ierr_en;
  wire mcer_dis;
  reg [1:0] ctrl_r;
  reg [31:0] rdata_nxt;

  // byte-enable function: lane for a given bit
  function lane_on;
    input [3:0] strb;
    input integer bitpos;
    begin
      lane_on = strb[bitpos / 8];
    end
  endfunction

  assign access = psel && penable && !pready;
  // writes land only at the edge that completes the transfer
  assign commit = psel && penable && pready;
  assign hit_sev = (paddr == `UESEV_OFFSET);
  assign hit_ctrl = (paddr == `UESEV_CTRL_OFFSET);
  assign wr_sev = commit && pwrite && hit_sev;
  assign wr_ctrl = commit && pwrite && hit_ctrl;

  assign ierr_en = ctrl_r[`CTRL_IERR_EN_BIT];
  assign mcer_dis = ctrl_r[`CTRL_MCER_DIS_BIT];

  // forced read-only overrides, index 6 is bit 22, index 7 is bit 23
  assign force_en = {!mcer_dis, !ierr_en, 6'h00};
  assign force_val = {1'b0, 1'b1, 6'h00};

  // sticky programmable fields, reset from SEV_RESET
  genvar g;
  generate
    for (g = 0; g < `SEV_W; g = g + 1) begin : gen_sev
      localparam [7:0] RV = `SEV_RESET;
      sev_field #(
        .RESET_VAL(RV[g])
      ) u_field (
        .pclk(pclk),
        .por_n(por_n),
        .wr_en(wr_sev && lane_on(pstrb, `SEV_LO + g)),
        .wr_bit(pwdata[`SEV_LO + g]),
        .force_en(force_en[g]),
        .force_val(force_val[g]),
        .value(sev_val[g])
      );
    end
  endgenerate

  // control word, sticky as well
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ctrl && pstrb[0]) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // read mux; bits 14, 15 and 31:24 read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_sev) begin
      rdata_nxt[`SEV_HI:`SEV_LO] = sev_val;
    end else if (hit_ctrl) begin
      rdata_nxt[1:0] = ctrl_r;
    end
  end

  // one wait state: ready the cycle after setup+access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access) begin
      pready <= 1'b1;
      pslverr <= !(hit_sev || hit_ctrl);
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // severity classification of each incoming error event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fatal_report <= 8'h00;
      nonfatal_report <= 8'h00;
      severity <= 8'h00;
    end else begin
      fatal_report <= err_event & sev_val;
      nonfatal_report <= err_event & ~sev_val;
      severity <= sev_val;
    end
  end
endmodule // uncorrectable_error_severity_upper
`default_nettype wire

//--- uesev_chk.sv
// checker for the severity bank ports
// bound to the bank at the foot
`default_nettype none
module uesev_chk (
  input wire logic pclk, presetn, por_n, psel, penable, pwrite,
  input wire logic pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [7:0] err_event, fatal_report, nonfatal_report, severity
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_ok; pready && !pslverr; endsequence
  a_one_wait: assert property (s_acc |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready");
  a_addr_map: assert property (pready |->
    pslverr == (paddr != 12'h10C && paddr != 12'h200)) else $error("map");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("err data");
  a_ro_low: assert property (
    s_ok |-> prdata[15:14] == 2'h0) else $error("ro bits");
  a_resv_zero: assert property (
    s_ok |-> prdata[31:24] == 8'h00) else $error("reserved");
  a_sev_split: assert property (
    (fatal_report & nonfatal_report) == 8'h00) else $error("split");
  a_event_out: assert property (
    (fatal_report | nonfatal_report) == $past(err_event)) else $error("ev");
  a_fatal_sel: assert property (
    fatal_report == ($past(err_event) & severity)) else $error("fatal");
  a_nonfatal_sel: assert property (
    nonfatal_report == ($past(err_event) & ~severity))
    else $error("nonfatal");
  a_read_sev: assert property (
    s_ok && !pwrite && paddr == 12'h10C |-> prdata[23:16] == severity)
    else $error("read sev");
endmodule // uesev_chk
bind uncorrectable_error_severity_upper uesev_chk chk_i (.pclk(pclk),
  .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata),
  .err_event(err_event), .fatal_report(fatal_report),
  .nonfatal_report(nonfatal_report), .severity(severity));
`default_nettype wire

//--- tb.sv
// bench for the severity bank
// drives apb, events and both resets
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] err_event = 8'h00, fatal_report, nonfatal_report, severity;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  uncorrectable_error_severity_upper dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .por_n, .err_event, .fatal_report, .nonfatal_report,
    .severity);
  initial forever #50 pclk = ~pclk;
  task automatic xf(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ck(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [31:0] exp);
    xf(1'b0, 12'h10C, 32'h0);
    ck(rd, exp);
  endtask
  task automatic t_forced;
    rc(32'h00460000);
    xf(1'b1, 12'h10C, 32'hFFFFFFFF);
    rc(32'h007F0000);
  endtask
  task automatic t_open;
    xf(1'b1, 12'h200, 32'h3);
    xf(1'b1, 12'h10C, 32'hFFFFFFFF);
    rc(32'h00FF0000);
    xf(1'b1, 12'h10C, 32'h00A50000);
    err_event <= 8'hFF;
    repeat (3) @(posedge pclk);
    ck({24'h0, fatal_report}, 32'hA5);
    ck({24'h0, nonfatal_report}, 32'h5A);
    ck({24'h0, severity}, 32'hA5);
    err_event <= 8'h00;
    xf(1'b1, 12'h200, 32'h1);
    rc(32'h00250000);
    xf(1'b1, 12'h200, 32'h2);
    rc(32'h00E50000);
    xf(1'b1, 12'h200, 32'h3);
    xf(1'b0, 12'h200, 32'h0);
    ck(rd, 32'h3);
  endtask
  task automatic t_strb;
    pstrb <= 4'hB;
    xf(1'b1, 12'h10C, 32'h0);
    pstrb <= 4'hF;
    xf(1'b1, 12'h00C, 32'h0);
    ck({31'h0, err}, 32'h1);
    rc(32'h00A50000);
  endtask
  task automatic t_warm;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(32'h00A50000);
    presetn <= 1'b0;
    por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rc(32'h00460000);
    ck({24'h0, severity}, 32'h46);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_forced();
    t_open();
    t_strb();
    t_warm();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
